// [rtl/gpp16_port.sv]
`timescale 1ns/100ps
`include "gpp16_defines.svh"
// How it works
// R01: sixteen lines in two halves, each half plain or alternate.
// R02: low half serves dma pins, high half serves serial control pins.
// R03: with dma and combine, tx and rx acks share one pin per channel.
// R04: a direction bit per line, zero input, one output.
// R05: inputs float, outputs driven push-pull high and low.
// R06: every pin level is sampled each clock whatever its direction.
// R07: input line: write hits latch, read gives pin, rmw uses pin.
// R08: output line: write drives pin, read and rmw use the latch.
// R09: alternate output reaches the pin only while direction is output.
// R10: pin drives latch AND alternate data; software keeps latch at one.
// R11: alternate input reads the pin, so an output latch can trigger it.
// R12: after reset all lines are inputs.
// R13: software loads the latch before turning a line to output.
// R14: vector is made on a peripheral interrupt only when enabled.
// R15: vector is 85h, 00h, high byte info, low byte info.
// R16: high byte info from pins 15..8 unless serial control selected.
// R17: low byte info from pins 7..0 unless dma selected.
// R18: direction, latches and selects all reset to zero.
module gpp16_port #(
  parameter int WIDTH = `GPP16_WIDTH,
  parameter int HALF = `GPP16_HALF
) (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire logic I_LOCAL_DMA_PIN_SELECT,
  input wire logic I_SERIAL_CONTROL_PIN_SELECT,
  input wire logic I_COMBINE_DMA_ACK_PINS,
  input wire logic I_PORT_INTERRUPT_ENABLE,
  input wire logic I_DIR_WR,
  input wire gpp16_pkg::gpp16_word_t I_DIR_DATA,
  input wire logic I_WR,
  input wire gpp16_pkg::gpp16_word_t I_WR_DATA,
  input wire logic I_RMW,
  input wire gpp16_pkg::gpp16_word_t I_RMW_AND,
  input wire gpp16_pkg::gpp16_word_t I_RMW_OR,
  input wire logic I_RD,
  input wire gpp16_pkg::gpp16_word_t I_PIN,
  input wire gpp16_pkg::gpp16_word_t I_ALT_OUT,
  input wire logic I_PERIPH_IRQ,
  output gpp16_pkg::gpp16_word_t O_PIN,
  output gpp16_pkg::gpp16_word_t O_PIN_OE,
  output gpp16_pkg::gpp16_word_t O_ALT_IN,
  output gpp16_pkg::gpp16_word_t O_RD_DATA,
  output logic O_RD_VALID,
  output gpp16_pkg::gpp16_word_t O_DIR,
  output gpp16_pkg::gpp16_vec_t O_PORT_INTERRUPT_VECTOR,
  output logic O_VEC_VALID
);
  import gpp16_pkg::*;

  // the vector layout fixes the port at two bytes
  if (WIDTH != 16 || HALF != 8 || WIDTH != 2 * HALF) begin : g_bad_size
    $error("gpp16_port: WIDTH must be 16 and HALF 8");
  end

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_meta <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_meta <= 1'h1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // configuration bits
  // ----------------------------------------
  logic sel_dma;
  logic sel_ssc;
  logic combine;
  logic irq_en;

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sel_dma <= 1'h0; // see R18
      sel_ssc <= 1'h0; // see R18
      combine <= 1'h0;
      irq_en <= 1'h0;
    end else begin
      sel_dma <= I_LOCAL_DMA_PIN_SELECT;
      sel_ssc <= I_SERIAL_CONTROL_PIN_SELECT;
      combine <= I_COMBINE_DMA_ACK_PINS;
      irq_en <= I_PORT_INTERRUPT_ENABLE;
    end
  end

  // ----------------------------------------
  // direction, output latch, input latch
  // ----------------------------------------
  gpp16_word_t dir;
  gpp16_word_t out_latch;
  gpp16_word_t pin_latch;

  // each line reads its latch when output, its pin when input
  wire gpp16_word_t read_src = (dir & out_latch) | (~dir & pin_latch);
  wire gpp16_word_t rmw_val = (read_src & I_RMW_AND) | I_RMW_OR;
  // a plain write wins over a read-modify-write in the same cycle
  wire gpp16_word_t next_out = I_WR ? I_WR_DATA :
                               (I_RMW ? rmw_val : out_latch);

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      dir <= `GPP16_RST_DIR; // see R12
      out_latch <= `GPP16_RST_OUT; // see R18
      pin_latch <= `GPP16_RST_OUT;
    end else begin
      if (I_DIR_WR) begin
        dir <= I_DIR_DATA; // see R04
      end
      out_latch <= next_out; // see R07
      pin_latch <= I_PIN; // see R06
    end
  end

  // ----------------------------------------
  // alternate function routing
  // ----------------------------------------
  wire logic merge = sel_dma & combine;
  wire gpp16_word_t half_mask = {{HALF{sel_ssc}}, {HALF{sel_dma}}}; // see R02
  // merged rx ack lines become free for plain i/o
  wire gpp16_word_t free_mask = merge ?
    ((16'h0001 << `GPP16_ACK_A_RX) | (16'h0001 << `GPP16_ACK_B_RX)) :
    16'h0000;
  wire gpp16_word_t alt_mask = half_mask & ~free_mask; // see R01
  wire logic ack_a = I_ALT_OUT[`GPP16_ACK_A_TX] &
                     I_ALT_OUT[`GPP16_ACK_A_RX];
  wire logic ack_b = I_ALT_OUT[`GPP16_ACK_B_TX] &
                     I_ALT_OUT[`GPP16_ACK_B_RX];
  // acks are low active, so the AND merges them
  wire gpp16_word_t alt_data = merge ?
    ((I_ALT_OUT & ~((16'h0001 << `GPP16_ACK_A_TX) |
                    (16'h0001 << `GPP16_ACK_B_TX))) |
     ({15'h0000, ack_a} << `GPP16_ACK_A_TX) |
     ({15'h0000, ack_b} << `GPP16_ACK_B_TX)) :
    I_ALT_OUT; // see R03
  // a latch zero forces the pin low even in alternate mode
  wire gpp16_word_t next_pin = out_latch & (alt_data | ~alt_mask); // see R10

  // ----------------------------------------
  // interrupt vector
  // ----------------------------------------
  wire gpp16_byte_t hi_info = sel_ssc ? `GPP16_VEC_ZERO :
                              pin_latch[15:8]; // see R16
  wire gpp16_byte_t lo_info = sel_dma ? `GPP16_VEC_ZERO :
                              pin_latch[7:0]; // see R17
  wire gpp16_vec_t next_vec = {`GPP16_VEC_TAG, `GPP16_VEC_ZERO,
                               hi_info, lo_info}; // see R15
  wire logic vec_fire = I_PERIPH_IRQ & irq_en; // see R14

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_PIN <= `GPP16_RST_OUT;
      O_PIN_OE <= `GPP16_RST_DIR;
      O_ALT_IN <= `GPP16_RST_OUT;
      O_RD_DATA <= `GPP16_RST_OUT;
      O_RD_VALID <= 1'h0;
      O_DIR <= `GPP16_RST_DIR;
      O_PORT_INTERRUPT_VECTOR <= `GPP16_VEC_RST;
      O_VEC_VALID <= 1'h0;
    end else begin
      O_PIN <= next_pin; // see R08
      O_PIN_OE <= dir; // see R05 see R09
      O_ALT_IN <= pin_latch & alt_mask; // see R11
      O_RD_VALID <= I_RD;
      if (I_RD) begin
        O_RD_DATA <= read_src; // see R07 see R08
      end
      O_DIR <= dir;
      O_VEC_VALID <= vec_fire;
      if (vec_fire) begin
        O_PORT_INTERRUPT_VECTOR <= next_vec;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!rst_n);

  a_oe_follows_dir: assert property ( // see R05
    I_DIR_WR ##2 1'h1 |-> O_PIN_OE == $past(I_DIR_DATA, 2)
  ) else $error("pin enable does not follow direction write");

  a_dir_reg: assert property ( // see R04
    I_DIR_WR ##2 1'h1 |-> O_DIR == $past(I_DIR_DATA, 2)
  ) else $error("direction bits not reported after write");

  a_oe_alt: assert property ( // see R09
    sel_dma || sel_ssc |=> O_PIN_OE == $past(dir)
  ) else $error("alternate mode changed the pin enable");

  a_write_to_pin: assert property ( // see R08
    I_WR ##1 half_mask == 16'h0000 |=> O_PIN == $past(I_WR_DATA, 2)
  ) else $error("written value missing on pin");

  a_write_latch: assert property ( // see R07
    I_WR |=> out_latch == $past(I_WR_DATA)
  ) else $error("write did not reach the output latch");

  a_rmw_output: assert property ( // see R08
    I_RMW && !I_WR && dir == 16'hFFFF
    |=> out_latch == (($past(out_latch) & $past(I_RMW_AND)) |
                      $past(I_RMW_OR))
  ) else $error("rmw on output line not based on latch");

  a_rd_pulse: assert property ( // see R07
    !I_RD |=> !O_RD_VALID
  ) else $error("read strobe without a read");

  a_read_output: assert property ( // see R08
    I_RD && dir == 16'hFFFF |=> O_RD_VALID && O_RD_DATA == $past(out_latch)
  ) else $error("read of output line not from latch");

  a_read_input: assert property ( // see R07
    I_RD && dir == 16'h0000 |=> O_RD_DATA == $past(I_PIN, 2)
  ) else $error("read of input line not from pin");

  a_rmw_input: assert property ( // see R07
    I_RMW && !I_WR && dir == 16'h0000
    |=> out_latch == (($past(I_PIN, 2) & $past(I_RMW_AND)) |
                      $past(I_RMW_OR))
  ) else $error("rmw on input line not based on pin");

  a_sample_pins: assert property ( // see R06
    ##2 pin_latch == $past(I_PIN)
  ) else $error("pin level not sampled every clock");

  a_plain_pin: assert property ( // see R01
    !sel_dma && !sel_ssc |=> O_PIN == $past(out_latch)
  ) else $error("plain line not driven by latch");

  a_low_plain: assert property ( // see R01
    !sel_dma |=> O_PIN[7:0] == $past(out_latch[7:0])
  ) else $error("plain low half not driven by latch");

  a_alt_and: assert property ( // see R10
    sel_ssc |=> O_PIN[15:8] == ($past(out_latch[15:8]) &
                                $past(I_ALT_OUT[15:8]))
  ) else $error("alternate output not ANDed with latch");

  a_combine_ack: assert property ( // see R03
    sel_dma && combine |=> O_PIN[0] == ($past(out_latch[0]) &
      $past(I_ALT_OUT[0]) & $past(I_ALT_OUT[1]))
  ) else $error("dma acks not merged on channel A pin");

  a_dma_free_line: assert property ( // see R03
    sel_dma && combine |=> O_PIN[1] == $past(out_latch[1])
  ) else $error("freed rx ack line not plain i/o");

  a_alt_in_pins: assert property ( // see R11
    sel_ssc |=> O_ALT_IN[15:8] == $past(I_PIN[15:8], 2)
  ) else $error("alternate input does not follow pins");

  a_vec_hold: assert property ( // see R14
    !vec_fire |=> $stable(O_PORT_INTERRUPT_VECTOR)
  ) else $error("vector changed without an interrupt");

  a_vec_enable: assert property ( // see R14
    I_PERIPH_IRQ |=> O_VEC_VALID == $past(irq_en)
  ) else $error("vector strobe disagrees with enable");

  a_vec_fmt: assert property ( // see R15
    O_VEC_VALID |-> O_PORT_INTERRUPT_VECTOR[31:16] == 16'h8500
  ) else $error("vector fixed pattern wrong");

  a_vec_high: assert property ( // see R16
    vec_fire && sel_ssc |=> O_PORT_INTERRUPT_VECTOR[15:8] == 8'h00
  ) else $error("high byte info not zero in serial mode");

  a_vec_high_info: assert property ( // see R16
    vec_fire && !sel_ssc
    |=> O_PORT_INTERRUPT_VECTOR[15:8] == $past(I_PIN[15:8], 2)
  ) else $error("high byte info not taken from pins");

  a_vec_low_zero: assert property ( // see R17
    vec_fire && sel_dma |=> O_PORT_INTERRUPT_VECTOR[7:0] == 8'h00
  ) else $error("low byte info not zero in dma mode");

  a_vec_low: assert property ( // see R17
    vec_fire && !sel_dma
    |=> O_PORT_INTERRUPT_VECTOR[7:0] == $past(pin_latch[7:0])
  ) else $error("low byte info not taken from pins");

  a_reset_input: assert property ( // see R12
    $rose(rst_n) |-> O_PIN_OE == 16'h0000 && dir == 16'h0000
  ) else $error("lines not inputs after reset");

  c_alt_dma: cover property (sel_dma && combine && dir != 16'h0000);
  c_alt_ssc: cover property (sel_ssc && I_WR ##1 I_RD);
  c_rmw_mix: cover property (I_RMW && dir != 16'h0000 && dir != 16'hFFFF);
  c_vec: cover property (vec_fire ##1 O_VEC_VALID);
  c_vec_off: cover property (I_PERIPH_IRQ && !irq_en);
endmodule

// [inc/gpp16_defines.svh]
`ifndef GPP16_DEFINES_SVH
`define GPP16_DEFINES_SVH

// ----------------------------------------
// port geometry and reset values
// ----------------------------------------
`define GPP16_WIDTH 16
`define GPP16_HALF 8
`define GPP16_RST_DIR 16'h0000
`define GPP16_RST_OUT 16'h0000
`define GPP16_ONES 16'hFFFF

// ----------------------------------------
// dma acknowledge line positions, low half
// ----------------------------------------
`define GPP16_ACK_A_TX 0
`define GPP16_ACK_A_RX 1
`define GPP16_ACK_B_TX 2
`define GPP16_ACK_B_RX 3

// ----------------------------------------
// interrupt vector layout
// ----------------------------------------
`define GPP16_VEC_TAG 8'h85
`define GPP16_VEC_ZERO 8'h00
`define GPP16_VEC_RST 32'h0000_0000

`endif

// [inc/gpp16_pkg.sv]
package gpp16_pkg;
  typedef logic [15:0] gpp16_word_t;
  typedef logic [7:0] gpp16_byte_t;
  typedef logic [31:0] gpp16_vec_t;
endpackage

// [verification/gpp16_pins.sv]
`timescale 1ns/100ps
// ----
// far side: one device per line
// ----
module gpp16_pins (
  input wire gpp16_pkg::gpp16_word_t i_pin_out,
  input wire gpp16_pkg::gpp16_word_t i_pin_oe,
  input wire gpp16_pkg::gpp16_word_t i_ext,
  output gpp16_pkg::gpp16_word_t o_pin
);
  import gpp16_pkg::*;
  // drives only floating lines, so no contention with the port
  assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext);
endmodule

// [verification/gpp16_port_tb.sv]
`timescale 1ns/100ps
module gpp16_port_tb;
  import gpp16_pkg::*;
  logic clk = 0;
  logic arst_n = 0;
  logic dma = 0, synchronous_serial_control = 0, comb = 0, ien = 0;
  logic dir_wr = 0, wr = 0, rmw = 0, rd = 0, irq = 0;
  gpp16_word_t dir_d = '0, wr_d = '0, m_and = '0, m_or = '0;
  gpp16_word_t ext = '0, alt = '0;
  gpp16_word_t pin, pin_o, oe, alt_in, rd_d, dir_o, lat, dir;
  gpp16_vec_t vec;
  logic rd_v, vec_v;
  int num_errors = 0, compares = 0, seed = 77126;
  always #5 clk = ~clk;
  gpp16_port u_gpp16_port (.I_CLK(clk), .I_ARST_N(arst_n),
    .I_LOCAL_DMA_PIN_SELECT(dma), .I_SERIAL_CONTROL_PIN_SELECT(synchronous_serial_control),
    .I_COMBINE_DMA_ACK_PINS(comb), .I_PORT_INTERRUPT_ENABLE(ien),
    .I_DIR_WR(dir_wr), .I_DIR_DATA(dir_d), .I_WR(wr), .I_WR_DATA(wr_d),
    .I_RMW(rmw), .I_RMW_AND(m_and), .I_RMW_OR(m_or), .I_RD(rd),
    .I_PIN(pin), .I_ALT_OUT(alt), .I_PERIPH_IRQ(irq), .O_PIN(pin_o),
    .O_PIN_OE(oe), .O_ALT_IN(alt_in), .O_RD_DATA(rd_d),
    .O_RD_VALID(rd_v), .O_DIR(dir_o), .O_PORT_INTERRUPT_VECTOR(vec),
    .O_VEC_VALID(vec_v));
  gpp16_pins u_gpp16_pins (.i_pin_out(pin_o), .i_pin_oe(oe),
    .i_ext(ext), .o_pin(pin));
  // ----
  // helpers
  // ----
  function automatic gpp16_word_t f_drv(gpp16_word_t l);
    f_drv = l & (~{{8{synchronous_serial_control}}, {8{dma}}} | alt);
    if (dma && comb) begin
      f_drv[0] = l[0] & alt[0] & alt[1];
      f_drv[1] = l[1];
      f_drv[2] = l[2] & alt[2] & alt[3];
      f_drv[3] = l[3];
    end
  endfunction
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input gpp16_vec_t g, input gpp16_vec_t e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic pls(ref logic s);
    s = 1'h1;
    step();
    s = 1'h0;
  endtask
  task automatic chk_all;
    gpp16_word_t px, m;
    gpp16_vec_t ev;
    px = (dir & f_drv(lat)) | (~dir & ext);
    m = {{8{synchronous_serial_control}}, {8{dma}}} & ~((dma & comb) ? 16'h000A : 16'h0000);
    chk(32'(oe), 32'(dir));
    chk(32'(dir_o), 32'(dir));
    chk(32'(pin_o), 32'(f_drv(lat)));
    chk(32'(alt_in), 32'(px & m));
    rd = 1'h1;
    irq = 1'h1;
    step();
    rd = 1'h0;
    irq = 1'h0;
    // valid strobes stand for one cycle only, so look right away
    chk(32'(rd_v), 32'h1);
    chk(32'(rd_d), 32'((dir & lat) | (~dir & ext)));
    chk(32'(vec_v), 32'(ien));
    ev = {8'h85, 8'h00, synchronous_serial_control ? 8'h00 : px[15:8], dma ? 8'h00 : px[7:0]};
    if (ien) chk(vec, ev);
  endtask
  task automatic complete_run;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (5) step();
    chk(32'(oe), 32'h0);
    chk(32'(pin_o), 32'h0);
    lat = '0;
    dir = '0;
    for (int i = 0; i < 40; i++) begin
      {dma, synchronous_serial_control, comb, ien} = 4'($random(seed));
      alt = 16'($random(seed));
      ext = 16'($random(seed));
      wr_d = 16'($random(seed));
      dir_d = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
      lat = wr_d;
      pls(wr);
      dir = dir_d;
      pls(dir_wr);
      // settle time covers the registered selects and pin path
      repeat (3) step();
      chk_all();
      m_and = 16'($random(seed));
      m_or = 16'($random(seed));
      lat = (((dir & lat) | (~dir & ext)) & m_and) | m_or;
      pls(rmw);
      repeat (3) step();
      chk_all();
    end
    arst_n = 1'b0;
    #2;
    chk(32'(oe), 32'h0);
    complete_run();
  end
endmodule
